// ===== dlsp_chk_assertions.sv
`timescale 1ns/10ps
module dlsp_chk (
	input logic clk_i, // system clock
	input logic rst_i, // async reset, active high
	input logic pll_reference_input_i, // reference clock
	input logic internal_width_select_i, // width select
	input logic lock_detector_enable_i, // lock detector enable
	input logic oversampling_enable_i, // oversampling mode
	input logic [2:0] feedback_divider_select_i, // feedback select
	input logic pll_lock_flag_o, // lock flag
	input logic reference_clock_passthrough_o, // reference copy
	input logic [27:0] common_config_value_o, // config value
	input logic [4:0] pll_mult_o, // pll multiplier
	input logic [2:0] width_factor_o, // width factor
	input logic [3:0] datapath_width_o, // datapath width
	input logic [2:0] parallel_div_o, // parallel divide
	input logic config_error_o, // illegal setting flag
	input logic settings_changed_o // change pulse
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	cfg_one_a: assert property (feedback_divider_select_i == 3'h1
		|=> common_config_value_o == 28'h1680A07)
		else $error("config value wrong for feedback one");
	cfg_dflt_a: assert property (feedback_divider_select_i != 3'h1
		|=> common_config_value_o == 28'h1680A0E)
		else $error("default config value wrong");
	fb_mult_a: assert property (internal_width_select_i && feedback_divider_select_i == 3'h2
		|=> pll_mult_o == 5'hA)
		else $error("pll multiplier wrong");
	wide_path_a: assert property (internal_width_select_i
		|=> datapath_width_o == 4'hA && parallel_div_o == 3'h5)
		else $error("wide path setting wrong");
	narrow_path_a: assert property (!internal_width_select_i
		|=> datapath_width_o == 4'h8 && parallel_div_o == 3'h4)
		else $error("narrow path setting wrong");
	ovs_factor_a: assert property (oversampling_enable_i |=> width_factor_o == 3'h5)
		else $error("oversampling width factor wrong");
	lock_off_a: assert property (!lock_detector_enable_i |=> !pll_lock_flag_o)
		else $error("lock high with detector off");
	ref_pass_a: assert property (1'b1 |=> reference_clock_passthrough_o == $past(pll_reference_input_i))
		else $error("reference copy wrong");
	err_lock_a: assert property (config_error_o |-> !pll_lock_flag_o)
		else $error("lock high with illegal settings");
	chg_lock_a: assert property (settings_changed_o |-> !pll_lock_flag_o)
		else $error("lock high right after a change");
	lock_c: cover property ($rose(pll_lock_flag_o));
	fb_one_c: cover property (feedback_divider_select_i == 3'h1);
	ovs_c: cover property (oversampling_enable_i && !internal_width_select_i);
	err_c: cover property ($rose(config_error_o));
endmodule
bind dlsp_pll_config dlsp_chk u_chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.pll_reference_input_i(pll_reference_input_i),
	.internal_width_select_i(internal_width_select_i),
	.lock_detector_enable_i(lock_detector_enable_i),
	.oversampling_enable_i(oversampling_enable_i),
	.feedback_divider_select_i(feedback_divider_select_i),
	.pll_lock_flag_o(pll_lock_flag_o),
	.reference_clock_passthrough_o(reference_clock_passthrough_o),
	.common_config_value_o(common_config_value_o),
	.pll_mult_o(pll_mult_o),
	.width_factor_o(width_factor_o),
	.datapath_width_o(datapath_width_o),
	.parallel_div_o(parallel_div_o),
	.config_error_o(config_error_o),
	.settings_changed_o(settings_changed_o)
);

// ===== dlsp_consts.vh
`ifndef DLSP_CONSTS_VH
`define DLSP_CONSTS_VH
`define DLSP_CFG_FB_ONE 28'h1680A07
`define DLSP_CFG_DEFAULT 28'h1680A0E
`define DLSP_W_NARROW 3'h4
`define DLSP_W_WIDE 3'h5
`define DLSP_WIDTH_NARROW 4'h8
`define DLSP_WIDTH_WIDE 4'hA
`define DLSP_FB_MIN 3'h1
`define DLSP_FB_MAX 3'h5
`define DLSP_FB_THREE 3'h3
`define DLSP_DIV_1 3'h1
`define DLSP_DIV_2 3'h2
`define DLSP_DIV_4 3'h4
`define DLSP_REF_1 2'h1
`define DLSP_REF_2 2'h2
`define DLSP_CLK_MHZ 50
`define DLSP_LOCK_NS 10000
`define DLSP_REF_TIMEOUT_NS 1000
`define DLSP_CNT_W 10
// lock time and reference timeout as clk cycles, at counter width
`define DLSP_LOCK_LIMIT 10'h1F4
`define DLSP_REF_LIMIT 10'h032
`define DLSP_CNT_ONE 10'h001
`define DLSP_DEN4_ONE 4'h1
`define DLSP_DEN6_ONE 6'h1
`endif

// ===== dlsp_pll_config.v
`timescale 1ns/10ps
`include "dlsp_consts.vh"
module dlsp_pll_config (
	input wire clk_i, // system clock
	input wire rst_i, // async reset, active high
	input wire pll_reference_input_i, // reference clock, sampled
	input wire internal_width_select_i, // 0: 8-bit, 1: 10-bit
	input wire lock_detector_enable_i, // lock detector enable
	input wire oversampling_enable_i, // oversampling mode
	input wire tx_buffer_bypass_i, // tx elastic buffer bypassed
	input wire [2:0] feedback_divider_select_i, // 1..5
	input wire [1:0] reference_divider_select_i, // 1 or 2
	input wire [2:0] rx_output_divider_lane0_i, // 1,2,4
	input wire [2:0] rx_output_divider_lane1_i, // 1,2,4
	input wire [2:0] tx_common_divider_i, // 1,2,4
	input wire [2:0] tx_output_divider_lane0_i, // 1,2,4
	input wire [2:0] tx_output_divider_lane1_i, // 1,2,4
	output reg pll_lock_flag_o, // pll settled
	output reg reference_clock_passthrough_o, // reference copy
	output reg [27:0] common_config_value_o, // required config value
	output reg [4:0] pll_mult_o, // pll / ref numerator
	output reg [1:0] pll_ref_div_o, // pll / ref denominator
	output reg [2:0] width_factor_o, // w, 4 or 5
	output reg [3:0] datapath_width_o, // 8 or 10 bits
	output reg [5:0] bit_rate_num_o, // 2 x pll numerator, all lanes
	output reg [3:0] rx_rate_den_lane0_o, // rx0 bit rate denominator
	output reg [3:0] rx_rate_den_lane1_o, // rx1 bit rate denominator
	output reg [5:0] tx_rate_den_lane0_o, // tx0 bit rate denominator
	output reg [5:0] tx_rate_den_lane1_o, // tx1 bit rate denominator
	output reg [2:0] parallel_div_o, // serial to parallel divide
	output reg config_error_o, // illegal setting present
	output reg settings_changed_o // one-cycle pulse on change
);

	function div_ok;
		input [2:0] sel;
		begin
			div_ok = (sel == `DLSP_DIV_1) || (sel == `DLSP_DIV_2) || (sel == `DLSP_DIV_4);
		end
	endfunction

	function [2:0] div_val;
		input [2:0] sel;
		begin
			div_val = div_ok(sel) ? sel : `DLSP_DIV_1;
		end
	endfunction

	reg ref_s_q;
	reg ref_prev_q;
	reg [`DLSP_CNT_W-1:0] lock_cnt_q;
	reg [`DLSP_CNT_W-1:0] lock_cnt_d;
	reg [`DLSP_CNT_W-1:0] ref_idle_q;
	reg [`DLSP_CNT_W-1:0] ref_idle_d;
	reg [25:0] cfg_prev_q;
	reg lock_d;

	wire ref_rise = ref_s_q & ~ref_prev_q;
	wire [2:0] fb = feedback_divider_select_i;
	wire [1:0] rdiv = reference_divider_select_i;
	wire [2:0] w_fac = (oversampling_enable_i || internal_width_select_i) ?
		`DLSP_W_WIDE : `DLSP_W_NARROW;
	wire [2:0] par_w = internal_width_select_i ? `DLSP_W_WIDE : `DLSP_W_NARROW;
	wire [25:0] cfg_now = {internal_width_select_i, oversampling_enable_i, tx_buffer_bypass_i,
		fb, rdiv, rx_output_divider_lane0_i, rx_output_divider_lane1_i,
		tx_common_divider_i, tx_output_divider_lane0_i, tx_output_divider_lane1_i, 3'h0};
	wire changed = (cfg_now != cfg_prev_q);

	reg fb_bad;
	reg ref_bad;
	reg div_bad;
	reg tx_bad;
	reg err_d;
	reg [4:0] mult_d;
	reg [5:0] num_d;
	reg [2:0] tx0_tot;
	reg [2:0] tx1_tot;
	reg [1:0] rdiv_v;

	always @* begin
		fb_bad = (fb < `DLSP_FB_MIN) || (fb > `DLSP_FB_MAX);
		if (!internal_width_select_i && ((fb == `DLSP_FB_THREE) || (fb == `DLSP_FB_MAX)))
			fb_bad = 1'b1;
		ref_bad = (rdiv != `DLSP_REF_1) && (rdiv != `DLSP_REF_2);
		div_bad = !div_ok(rx_output_divider_lane0_i) || !div_ok(rx_output_divider_lane1_i) ||
			!div_ok(tx_common_divider_i) || !div_ok(tx_output_divider_lane0_i) ||
			!div_ok(tx_output_divider_lane1_i);
		tx_bad = 1'b0;
		if (tx_common_divider_i != `DLSP_DIV_1 && (tx_output_divider_lane0_i != `DLSP_DIV_1 ||
			tx_output_divider_lane1_i != `DLSP_DIV_1))
			tx_bad = 1'b1;
		if (tx_buffer_bypass_i && (tx_output_divider_lane0_i != `DLSP_DIV_1 ||
			tx_output_divider_lane1_i != `DLSP_DIV_1))
			tx_bad = 1'b1;
		err_d = fb_bad | ref_bad | div_bad | tx_bad;
		rdiv_v = ref_bad ? `DLSP_REF_1 : rdiv;
		mult_d = fb_bad ? 5'h0 : ({2'h0, fb} * {2'h0, w_fac});
		num_d = {mult_d, 1'b0};
		tx0_tot = (tx_common_divider_i != `DLSP_DIV_1) ? div_val(tx_common_divider_i) :
			div_val(tx_output_divider_lane0_i);
		tx1_tot = (tx_common_divider_i != `DLSP_DIV_1) ? div_val(tx_common_divider_i) :
			div_val(tx_output_divider_lane1_i);
	end

	// lock: enabled, legal, stable settings and a live reference for the full lock time
	always @* begin
		ref_idle_d = ref_idle_q;
		if (ref_rise)
			ref_idle_d = {`DLSP_CNT_W{1'b0}};
		else if (ref_idle_q != `DLSP_REF_LIMIT)
			ref_idle_d = ref_idle_q + `DLSP_CNT_ONE;
	end

	always @* begin
		lock_cnt_d = lock_cnt_q;
		lock_d = 1'b0;
		if (!lock_detector_enable_i || err_d || changed ||
			ref_idle_q == `DLSP_REF_LIMIT) begin
			lock_cnt_d = {`DLSP_CNT_W{1'b0}};
		end else if (lock_cnt_q != `DLSP_LOCK_LIMIT) begin
			lock_cnt_d = lock_cnt_q + `DLSP_CNT_ONE;
		end else begin
			lock_d = 1'b1;
		end
	end

	// reference pin sample
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ref_s_q <= 1'b0;
		end else begin
			ref_s_q <= pll_reference_input_i;
		end
	end

	// previous reference sample for edge detect
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ref_prev_q <= 1'b0;
		end else begin
			ref_prev_q <= ref_s_q;
		end
	end

	// lock time counter
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lock_cnt_q <= {`DLSP_CNT_W{1'b0}};
		end else begin
			lock_cnt_q <= lock_cnt_d;
		end
	end

	// cycles since the last reference rise
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ref_idle_q <= {`DLSP_CNT_W{1'b0}};
		end else begin
			ref_idle_q <= ref_idle_d;
		end
	end

	// settings of the last cycle, for change detect
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_prev_q <= 26'h0;
		end else begin
			cfg_prev_q <= cfg_now;
		end
	end

	// lock flag, low during any bad condition
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pll_lock_flag_o <= 1'b0;
		end else begin
			pll_lock_flag_o <= lock_d;
		end
	end

	// reference copy for fabric logic
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			reference_clock_passthrough_o <= 1'b0;
		end else begin
			reference_clock_passthrough_o <= pll_reference_input_i;
		end
	end

	// required common configuration value
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			common_config_value_o <= `DLSP_CFG_DEFAULT;
		end else begin
			common_config_value_o <= (fb == `DLSP_FB_MIN) ? `DLSP_CFG_FB_ONE : `DLSP_CFG_DEFAULT;
		end
	end

	// pll over reference multiplier
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pll_mult_o <= 5'h0;
		end else begin
			pll_mult_o <= mult_d;
		end
	end

	// reference divide, illegal taken as one
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pll_ref_div_o <= `DLSP_REF_1;
		end else begin
			pll_ref_div_o <= rdiv_v;
		end
	end

	// feedback width factor
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			width_factor_o <= `DLSP_W_NARROW;
		end else begin
			width_factor_o <= w_fac;
		end
	end

	// internal parallel width of the tile
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			datapath_width_o <= `DLSP_WIDTH_NARROW;
		end else begin
			datapath_width_o <= internal_width_select_i ? `DLSP_WIDTH_WIDE : `DLSP_WIDTH_NARROW;
		end
	end

	// bit rate numerator, both edges used
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bit_rate_num_o <= 6'h0;
		end else begin
			bit_rate_num_o <= num_d;
		end
	end

	// lane 0 receive denominator
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_rate_den_lane0_o <= `DLSP_DEN4_ONE;
		end else begin
			rx_rate_den_lane0_o <= {2'h0, rdiv_v} * {1'b0, div_val(rx_output_divider_lane0_i)};
		end
	end

	// lane 1 receive denominator
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_rate_den_lane1_o <= `DLSP_DEN4_ONE;
		end else begin
			rx_rate_den_lane1_o <= {2'h0, rdiv_v} * {1'b0, div_val(rx_output_divider_lane1_i)};
		end
	end

	// lane 0 transmit denominator
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_rate_den_lane0_o <= `DLSP_DEN6_ONE;
		end else begin
			tx_rate_den_lane0_o <= {4'h0, rdiv_v} * {3'h0, tx0_tot};
		end
	end

	// lane 1 transmit denominator
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_rate_den_lane1_o <= `DLSP_DEN6_ONE;
		end else begin
			tx_rate_den_lane1_o <= {4'h0, rdiv_v} * {3'h0, tx1_tot};
		end
	end

	// serial to parallel divide, oversampling ignored
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			parallel_div_o <= `DLSP_W_NARROW;
		end else begin
			parallel_div_o <= par_w;
		end
	end

	// any illegal setting present
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			config_error_o <= 1'b0;
		end else begin
			config_error_o <= err_d;
		end
	end

	// one-cycle pulse on a settings change
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			settings_changed_o <= 1'b0;
		end else begin
			settings_changed_o <= changed;
		end
	end

endmodule

// ===== dlsp_ref_osc.sv
`timescale 1ns/10ps
module dlsp_ref_osc (
	input wire clk_i, // system clock
	input wire run_i, // oscillator running
	output logic ref_o = 1'b0 // reference clock to tile
);
	logic [1:0] cnt_q = 2'h0;
	// stands still when stopped so lock loss shows
	always @(posedge clk_i) begin
		cnt_q <= cnt_q + 2'h1;
		if (run_i && cnt_q == 2'h3) begin
			ref_o <= ~ref_o;
		end
	end
endmodule

// ===== dual_lane_shared_pll_config_tb.sv
`timescale 1ns/10ps
module dual_lane_shared_pll_config_tb;
	logic clk_i = 0, rst_i = 1, run = 1, ws = 1, en = 1, ov = 0, by = 0;
	logic [2:0] fb = 3'h2, rx = 3'h1, rq = 3'h1, tc = 3'h1, t0 = 3'h1, t1 = 3'h1;
	logic [1:0] rd = 2'h1;
	logic lk_s1 = 0, lk_s2 = 0;
	wire rf, lk, er, sc;
	wire [1:0] pr;
	wire [27:0] cf;
	wire [4:0] mu;
	wire [2:0] wf;
	wire [3:0] r0, r1;
	wire [5:0] nm, d0, d1;
	int fail_count = 0, total_checks = 0, cyc = 0;
	dlsp_ref_osc osc (.clk_i(clk_i), .run_i(run), .ref_o(rf));
	dlsp_pll_config dut (.clk_i(clk_i), .rst_i(rst_i), .pll_reference_input_i(rf), .internal_width_select_i(ws),
		.lock_detector_enable_i(en), .oversampling_enable_i(ov), .tx_buffer_bypass_i(by),
		.feedback_divider_select_i(fb), .reference_divider_select_i(rd), .rx_output_divider_lane0_i(rx),
		.rx_output_divider_lane1_i(rq), .tx_common_divider_i(tc), .tx_output_divider_lane0_i(t0),
		.tx_output_divider_lane1_i(t1), .pll_lock_flag_o(lk), .reference_clock_passthrough_o(),
		.common_config_value_o(cf), .pll_mult_o(mu), .pll_ref_div_o(pr), .width_factor_o(wf),
		.datapath_width_o(), .bit_rate_num_o(nm), .rx_rate_den_lane0_o(r0), .rx_rate_den_lane1_o(r1),
		.tx_rate_den_lane0_o(d0), .tx_rate_den_lane1_o(d1), .parallel_div_o(), .config_error_o(er),
		.settings_changed_o(sc));
	initial forever #10 clk_i = ~clk_i;
	// fabric-side two-stage synchroniser of the lock flag
	always @(posedge clk_i) begin
		lk_s1 <= lk;
		lk_s2 <= lk_s1;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	task tick;
		@(posedge clk_i);
		#2;
	endtask
	task chk(logic [27:0] got, logic [27:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) tick();
		rst_i = 0;
		tick();
		chk(sc, 1'h1);
		tick();
		chk(sc, 1'h0);
		chk(cf, 28'h1680A0E);
		chk(mu, 5'hA);
		chk(nm, 6'h14);
		chk(pr, 2'h1);
		repeat (600) if (lk !== 1'h1) tick();
		chk(lk, 1'h1);
		tick();
		tick();
		chk(lk_s2, 1'h1);
		run = 0;
		repeat (60) tick();
		chk(lk, 1'h0);
		run = 1;
		repeat (600) if (lk !== 1'h1) tick();
		chk(lk, 1'h1);
		fb = 3'h1;
		tick();
		chk(cf, 28'h1680A07);
		chk(lk, 1'h0);
		chk(sc, 1'h1);
		rd = 2'h2;
		rx = 3'h4;
		rq = 3'h2;
		tc = 3'h2;
		t0 = 3'h2;
		tick();
		chk(pr, 2'h2);
		chk(r0, 4'h8);
		chk(r1, 4'h4);
		chk(d0, 6'h4);
		chk(er, 1'h1);
		tc = 3'h1;
		t1 = 3'h4;
		tick();
		chk(d0, 6'h4);
		chk(d1, 6'h8);
		chk(er, 1'h0);
		by = 1;
		tick();
		chk(er, 1'h1);
		by = 0;
		ws = 0;
		fb = 3'h3;
		ov = 1;
		tick();
		chk(er, 1'h1);
		chk(wf, 3'h5);
		ov = 0;
		fb = 3'h4;
		tick();
		chk(mu, 5'h10);
		chk(wf, 3'h4);
		chk(er, 1'h0);
		rd = 2'h3;
		tick();
		chk(er, 1'h1);
		chk(pr, 2'h1);
		rd = 2'h1;
		repeat (600) if (lk !== 1'h1) tick();
		chk(lk, 1'h1);
		en = 0;
		tick();
		chk(lk, 1'h0);
		en = 1;
		tick();
		tally_and_finish();
	end
endmodule
